// ==== fbe_bank.sv ====
// Fieldbus interface enable register bank
`timescale 1ns/1ps
module fbe_bank import fbe_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [23:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] avail_strap_i,
  input wire logic [31:0] mask_strap_i,
  output logic [31:0] reg_rdata_o,
  output logic [31:0] ctrl_o,
  output logic [31:0] enabled_o,
  output logic [6:0] phy_enabled_o,
  output logic [2:0] proto_enabled_o,
  output logic access_err_o,
  output logic write_refused_o,
  output logic ready_o
);

  typedef enum logic [2:0] {
    FBE_REG_NONE = 3'b000,
    FBE_REG_AVAIL = 3'b001,
    FBE_REG_CTRL = 3'b011,
    FBE_REG_HIGHEST = 3'b010,
    FBE_REG_MASK = 3'b110,
    FBE_REG_ENABLED = 3'b111
  } fbe_reg_t;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] enabled;
    logic [31:0] rdata;
    logic [6:0] phy_en;
    logic [2:0] proto_en;
    logic err;
    logic refused;
    logic ready;
  } fbe_bank_state_t;

  fbe_bank_state_t s_r;
  fbe_bank_state_t s_nxt;

  logic [31:0] avail;
  logic [31:0] mask;
  logic loaded;
  logic [31:0] ctrl_merged;
  logic [31:0] ctrl_refused;
  fbe_reg_t rd_sel;
  fbe_reg_t wr_sel;
  logic [31:0] rd_word;
  logic [31:0] active;

  // Address decode, shared by read and write
  function automatic fbe_reg_t fbe_decode(input logic [23:0] addr);
    case (addr)
      FBE_ADDR_AVAIL: fbe_decode = FBE_REG_AVAIL;
      FBE_ADDR_CTRL: fbe_decode = FBE_REG_CTRL;
      FBE_ADDR_HIGHEST: fbe_decode = FBE_REG_HIGHEST;
      FBE_ADDR_MASK: fbe_decode = FBE_REG_MASK;
      FBE_ADDR_ENABLED: fbe_decode = FBE_REG_ENABLED;
      default: fbe_decode = FBE_REG_NONE;
    endcase
  endfunction

  // Physical half of a word
  function automatic logic [6:0] fbe_phy(input logic [31:0] w);
    fbe_phy = {w[FBE_BIT_SPI], w[FBE_BIT_REALTIME_ETHERNET],
               w[FBE_BIT_ETHERNET_PORT], w[FBE_BIT_CAN], w[FBE_BIT_RS232],
               w[FBE_BIT_RS485], w[FBE_BIT_USB]};
  endfunction

  // Protocol half of a word
  function automatic logic [2:0] fbe_proto(input logic [31:0] w);
    fbe_proto = {w[FBE_BIT_INDUSTRIAL_IP], w[FBE_BIT_TCP_MODBUS],
                 w[FBE_BIT_SERIAL_MODBUS]};
  endfunction

  fbe_strap u_strap (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .avail_strap_i(avail_strap_i),
    .mask_strap_i(mask_strap_i),
    .avail_o(avail),
    .mask_o(mask),
    .loaded_o(loaded)
  );

  fbe_merge u_merge (
    .ctrl_i(s_r.ctrl),
    .wdata_i(reg_wdata_i),
    .avail_i(avail),
    .mask_i(mask),
    .ctrl_o(ctrl_merged),
    .refused_o(ctrl_refused)
  );

  always_comb begin
    rd_sel = fbe_decode(reg_addr_i);
    wr_sel = fbe_decode(reg_addr_i);
    // Read multiplexer
    case (rd_sel)
      FBE_REG_AVAIL: rd_word = avail;
      FBE_REG_CTRL: rd_word = s_r.ctrl;
      FBE_REG_HIGHEST: rd_word = {24'h00_0000, FBE_RST_HIGHEST};
      FBE_REG_MASK: rd_word = mask;
      FBE_REG_ENABLED: rd_word = s_r.enabled;
      default: rd_word = FBE_ZERO;
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.err = 1'b0;
    s_nxt.refused = 1'b0;
    // Read data stand one cycle only
    s_nxt.rdata = reg_rd_i ? rd_word : FBE_ZERO;
    if (reg_rd_i && (rd_sel == FBE_REG_NONE)) begin
      s_nxt.err = 1'b1;
    end
    if (reg_wr_i) begin
      case (wr_sel)
        FBE_REG_CTRL: begin
          s_nxt.ctrl = ctrl_merged;
          s_nxt.refused = |ctrl_refused;
        end
        default: begin
          // Read-only and unmapped words ignore writes
          s_nxt.err = 1'b1;
        end
      endcase
    end
    // Active entries follow control where present
    active = s_nxt.ctrl & avail & FBE_DEFINED_BITS;
    s_nxt.enabled = active;
    s_nxt.phy_en = fbe_phy(active);
    s_nxt.proto_en = fbe_proto(active);
    s_nxt.ready = loaded;
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      s_r.ctrl <= FBE_RST_CTRL;
      s_r.enabled <= FBE_RST_ENABLED;
      s_r.rdata <= FBE_ZERO;
      s_r.phy_en <= fbe_phy(FBE_RST_ENABLED);
      s_r.proto_en <= fbe_proto(FBE_RST_ENABLED);
      s_r.err <= 1'b0;
      s_r.refused <= 1'b0;
      s_r.ready <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata_o = s_r.rdata;
  assign ctrl_o = s_r.ctrl;
  assign enabled_o = s_r.enabled;
  assign phy_enabled_o = s_r.phy_en;
  assign proto_enabled_o = s_r.proto_en;
  assign access_err_o = s_r.err;
  assign write_refused_o = s_r.refused;
  assign ready_o = s_r.ready;

endmodule

// ==== fbe_bank_sva.sv ====
// Assertions for the interface enable bank
`timescale 1ns/1ps
module fbe_bank_sva import fbe_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [23:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] avail_strap_i,
  input wire logic [31:0] mask_strap_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [31:0] ctrl_o,
  input wire logic [31:0] enabled_o,
  input wire logic [6:0] phy_enabled_o,
  input wire logic [2:0] proto_enabled_o,
  input wire logic access_err_o,
  input wire logic write_refused_o,
  input wire logic ready_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [31:0] sw;
  assign sw = avail_strap_i & mask_strap_i & FBE_DEFINED_BITS;
  sequence s_ctrl_wr;
    reg_wr_i && reg_addr_i == FBE_ADDR_CTRL && ready_o;
  endsequence
  a_phy_bits: assert property (phy_enabled_o == enabled_o[6:0])
    else $error("phy bits differ from status");
  a_status_calc: assert property (ready_o && $past(ready_o) |->
    enabled_o == (ctrl_o & avail_strap_i & FBE_DEFINED_BITS))
    else $error("status differs from control and availability");
  a_ctrl_hold: assert property (!(reg_wr_i && reg_addr_i == FBE_ADDR_CTRL)
    |=> $stable(ctrl_o)) else $error("control changed without write");
  a_ctrl_lock: assert property (ready_o |=>
    ((ctrl_o ^ $past(ctrl_o)) & ~sw) == 32'h0) else $error("locked bit changed");
  a_ctrl_take: assert property (s_ctrl_wr |=>
    (ctrl_o & sw) == ($past(reg_wdata_i) & sw)) else $error("control write lost");
  a_refuse_pulse: assert property (s_ctrl_wr ##0
    ((reg_wdata_i ^ ctrl_o) & ~sw) != 32'h0 |=> write_refused_o)
    else $error("no refusal pulse");
  a_high_sub: assert property (reg_rd_i && reg_addr_i == FBE_ADDR_HIGHEST
    |=> reg_rdata_o == 32'h0000_0002) else $error("highest subindex wrong");
  a_ro_write: assert property (reg_wr_i && reg_addr_i != FBE_ADDR_CTRL
    |=> access_err_o) else $error("read-only write not flagged");
  a_proto_bits: assert property (proto_enabled_o == enabled_o[18:16])
    else $error("protocol bits differ from status");
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data outside read cycle");
endmodule
bind fbe_bank fbe_bank_sva u_sva (.sys_clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .reg_rd_i, .avail_strap_i, .mask_strap_i, .reg_rdata_o, .ctrl_o,
  .enabled_o, .phy_enabled_o, .proto_enabled_o, .access_err_o, .write_refused_o,
  .ready_o);

// ==== fbe_bank_test.sv ====
// Self-checking bench for the interface enable bank
`timescale 1ns/1ps
module fbe_bank_test import fbe_pkg::*; ;
  localparam logic [31:0] AV = 32'h0007_0033;
  localparam logic [31:0] MK = 32'h0005_0021;
  localparam logic [31:0] SW = AV & MK & FBE_DEFINED_BITS;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [23:0] addr = 24'h0;
  logic [31:0] wdata = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [31:0] rdata, ctrl, enab, d;
  logic [31:0] c = FBE_RST_CTRL;
  logic [6:0] phy;
  logic [2:0] proto;
  logic err, refused, ready;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  fbe_bank u_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .avail_strap_i(AV),
    .mask_strap_i(MK), .reg_rdata_o(rdata), .ctrl_o(ctrl), .enabled_o(enab),
    .phy_enabled_o(phy), .proto_enabled_o(proto), .access_err_o(err),
    .write_refused_o(refused), .ready_o(ready));
  initial begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic bus_wr(input logic [23:0] a, input logic [31:0] v);
    @(posedge sys_clk_i);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge sys_clk_i);
    wr_s <= 1'b0;
    #1;
  endtask
  task automatic bus_rd(input logic [23:0] a, output logic [31:0] v);
    @(posedge sys_clk_i);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge sys_clk_i);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic do_ctrl(input logic [31:0] v);
    logic r;
    r = ((v ^ c) & ~SW) != 32'h0;
    c = (c & ~SW) | (v & SW);
    bus_wr(FBE_ADDR_CTRL, v);
    chk("ctrl", c, ctrl);
    chk("refused", {31'h0, r}, {31'h0, refused});
    chk("ctrl err", 32'h0, {31'h0, err});
    chk("enabled", c & AV & FBE_DEFINED_BITS, enab);
    chk("phy", {25'h0, c[6:0] & AV[6:0]}, {25'h0, phy});
    chk("proto", {29'h0, c[18:16] & AV[18:16]}, {29'h0, proto});
    bus_rd(FBE_ADDR_ENABLED, d);
    chk("status rd", c & AV & FBE_DEFINED_BITS, d);
  endtask
  task automatic t_reads();
    bus_rd(FBE_ADDR_AVAIL, d);
    chk("avail", AV, d);
    bus_rd(FBE_ADDR_HIGHEST, d);
    chk("highest", 32'h0000_0002, d);
    @(posedge sys_clk_i);
    #1;
    chk("rdata idle", 32'h0, rdata);
    bus_rd(FBE_ADDR_MASK, d);
    chk("mask", MK, d);
    bus_rd(24'h2104_00, d);
    chk("unmapped", 32'h0, d);
    chk("unmapped err", 32'h1, {31'h0, err});
    $display("reads done");
  endtask
  task automatic t_ctrl();
    do_ctrl(32'hffff_ffff);
    do_ctrl(32'h0);
    for (int b = 0; b < 32; b++) begin
      if (FBE_DEFINED_BITS[b]) begin
        do_ctrl(32'h1 << b);
      end
    end
    bus_rd(FBE_ADDR_CTRL, d);
    chk("ctrl rd", c, d);
    $display("control done");
  endtask
  task automatic t_ro();
    bus_wr(FBE_ADDR_MASK, 32'hffff_ffff);
    chk("mask wr err", 32'h1, {31'h0, err});
    bus_rd(FBE_ADDR_MASK, d);
    chk("mask kept", MK, d);
    bus_wr(FBE_ADDR_AVAIL, 32'h0);
    bus_rd(FBE_ADDR_AVAIL, d);
    chk("avail kept", AV, d);
    chk("ctrl kept", c, ctrl);
    $display("read-only done");
  endtask
  task automatic t_rst();
    @(posedge sys_clk_i);
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    #1;
    c = FBE_RST_CTRL;
    chk("rerun ctrl", c, ctrl);
    chk("rerun enabled", FBE_RST_ENABLED, enab);
    chk("rerun ready", 32'h0, {31'h0, ready});
    wait (ready === 1'b1);
    bus_rd(FBE_ADDR_ENABLED, d);
    chk("rerun status", c & AV & FBE_DEFINED_BITS, d);
    bus_rd(FBE_ADDR_AVAIL, d);
    chk("rerun avail", AV, d);
    $display("reset rerun done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      err_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    #1;
    chk("rst ctrl", FBE_RST_CTRL, ctrl);
    chk("rst enabled", FBE_RST_ENABLED, enab);
    chk("rst ready", 32'h0, {31'h0, ready});
    wait (ready === 1'b1);
    t_reads();
    t_ctrl();
    t_ro();
    t_rst();
    report_and_stop();
  end
endmodule

// ==== fbe_merge.sv ====
// Merges a control write with the bits software may switch
`timescale 1ns/1ps
module fbe_merge import fbe_pkg::*; (
  input wire logic [31:0] ctrl_i,
  input wire logic [31:0] wdata_i,
  input wire logic [31:0] avail_i,
  input wire logic [31:0] mask_i,
  output logic [31:0] ctrl_o,
  output logic [31:0] refused_o
);

  function automatic logic [31:0] fbe_switchable(input logic [31:0] avail,
                                                 input logic [31:0] mask);
    fbe_switchable = avail & mask & FBE_DEFINED_BITS;
  endfunction

  logic [31:0] sw;

  always_comb begin
    sw = fbe_switchable(avail_i, mask_i);
    // Locked or absent entries keep their value
    ctrl_o = (ctrl_i & ~sw) | (wdata_i & sw);
    refused_o = (ctrl_i ^ wdata_i) & ~sw;
  end

endmodule

// ==== fbe_pkg.sv ====
// Constants for the fieldbus interface enable bank
package fbe_pkg;

  // Register address: {object index, subindex}
  localparam int FBE_ADDR_W = 24;
  localparam int FBE_DATA_W = 32;
  localparam logic [15:0] FBE_IDX_AVAIL = 16'h2101;
  localparam logic [15:0] FBE_IDX_CTRL = 16'h2102;
  localparam logic [15:0] FBE_IDX_STATUS = 16'h2103;
  localparam logic [7:0] FBE_SUB_HIGHEST = 8'h00;
  localparam logic [7:0] FBE_SUB_MASK = 8'h01;
  localparam logic [7:0] FBE_SUB_ENABLED = 8'h02;
  localparam logic [23:0] FBE_ADDR_AVAIL = {FBE_IDX_AVAIL, 8'h00};
  localparam logic [23:0] FBE_ADDR_CTRL = {FBE_IDX_CTRL, 8'h00};
  localparam logic [23:0] FBE_ADDR_HIGHEST = {FBE_IDX_STATUS, FBE_SUB_HIGHEST};
  localparam logic [23:0] FBE_ADDR_MASK = {FBE_IDX_STATUS, FBE_SUB_MASK};
  localparam logic [23:0] FBE_ADDR_ENABLED = {FBE_IDX_STATUS, FBE_SUB_ENABLED};

  // Reset values
  localparam logic [31:0] FBE_RST_AVAIL = 32'h0019_0001;
  localparam logic [31:0] FBE_RST_CTRL = 32'h0008_0001;
  localparam logic [7:0] FBE_RST_HIGHEST = 8'h02;
  localparam logic [31:0] FBE_RST_MASK = 32'h0000_0000;
  localparam logic [31:0] FBE_RST_ENABLED = 32'h0008_0001;

  // Split between physical interfaces and protocols
  localparam int FBE_PHY_LSB = 0;
  localparam int FBE_PHY_MSB = 15;
  localparam int FBE_PROTO_LSB = 16;
  localparam int FBE_PROTO_MSB = 31;

  // Bit positions of each interface and protocol
  localparam int FBE_BIT_USB = 0;
  localparam int FBE_BIT_RS485 = 1;
  localparam int FBE_BIT_RS232 = 2;
  localparam int FBE_BIT_CAN = 3;
  localparam int FBE_BIT_ETHERNET_PORT = 4;
  localparam int FBE_BIT_REALTIME_ETHERNET = 5;
  localparam int FBE_BIT_SPI = 6;
  localparam int FBE_BIT_SERIAL_MODBUS = 16;
  localparam int FBE_BIT_TCP_MODBUS = 17;
  localparam int FBE_BIT_INDUSTRIAL_IP = 18;

  // All bits that name an interface or protocol
  localparam logic [31:0] FBE_DEFINED_BITS = 32'h0007_007f;

  localparam logic [31:0] FBE_ZERO = 32'h0000_0000;

endpackage

// ==== fbe_strap.sv ====
// Captures availability and disable-mask straps after reset release
`timescale 1ns/1ps
module fbe_strap import fbe_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [31:0] avail_strap_i,
  input wire logic [31:0] mask_strap_i,
  output logic [31:0] avail_o,
  output logic [31:0] mask_o,
  output logic loaded_o
);

  typedef enum logic [1:0] {
    FBE_ST_WAIT = 2'b00,
    FBE_ST_LOAD = 2'b01,
    FBE_ST_RUN = 2'b11
  } fbe_strap_st_t;

  typedef struct packed {
    fbe_strap_st_t st;
    logic [31:0] avail;
    logic [31:0] mask;
    logic loaded;
  } fbe_strap_state_t;

  fbe_strap_state_t s_r;
  fbe_strap_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    case (s_r.st)
      FBE_ST_WAIT: begin
        s_nxt.st = FBE_ST_LOAD;
      end
      FBE_ST_LOAD: begin
        // Availability and mask reflect fitted hardware
        s_nxt.avail = avail_strap_i;
        s_nxt.mask = mask_strap_i;
        s_nxt.loaded = 1'b1;
        s_nxt.st = FBE_ST_RUN;
      end
      FBE_ST_RUN: begin
        s_nxt.st = FBE_ST_RUN;
      end
      default: begin
        s_nxt.st = FBE_ST_WAIT;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      s_r.st <= FBE_ST_WAIT;
      s_r.avail <= FBE_RST_AVAIL;
      s_r.mask <= FBE_RST_MASK;
      s_r.loaded <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avail_o = s_r.avail;
  assign mask_o = s_r.mask;
  assign loaded_o = s_r.loaded;

endmodule
